// ==== verilog/fpp_pkg.sv ====
// Behaviour
// - Default space maps user code read-only to code reads; no writes that way.
// - With the buffer map bit set, data writes load the write-only page buffer.
// - Address bits 6..0 pick the byte in a page; bits 15..7 pick the page.
// - The buffer map bit overrides the external RAM select for data writes.
// - Space select 00 code, 01 signature, 10 fuses, 11 reserved for code reads.
// - Programming launches only after key nibble 5 then key nibble A.
// - First key does nothing; second writes buffer to the selected space, 11 none.
// - Any instruction between the two key writes aborts the launch; a write to the EEPROM or aux control register does not.
// - Busy stays high while programming runs and clears when it ends.
// - A brown-out that cuts programming short sets the error flag.
// - Buffer holds 64 bytes, one half of a 128-byte page per cycle.
// - Any count of loaded bytes from 1 to 64 may be programmed.
// - A loaded buffer location ignores further loads until cleared.
// - The whole buffer clears at the end of every write, which follows any auto-erase, and on a brown-out during programming.
// - Without auto-erase only loaded bytes are programmed; others stay unchanged.
// - Auto-erase erases the full page first; unloaded bytes end up blank.
// - The programmed page is the last page used while loading the buffer.
// - Launch from internal memory stalls the CPU; external launch polls busy.
// - Flash writes only clear bits; erase sets every page byte to FF.
// - Busy is changed by hardware only; software writes leave it alone.
package fpp_pkg;
    // Register map, byte addresses on the 32-bit bus
    localparam int             FPP_AXI_AW          = 8;
    localparam logic [7:0]     FPP_OFS_FLASH_CTRL  = 8'h00;
    localparam logic [7:0]     FPP_OFS_EEPROM_CTRL = 8'h04;
    localparam logic [7:0]     FPP_OFS_AUX_CTRL    = 8'h08;
    localparam logic [1:0]     FPP_RESP_OKAY       = 2'h0;
    localparam logic [1:0]     FPP_RESP_SLVERR     = 2'h2;

    // Field positions
    localparam int             FPP_KEY_LSB         = 4;
    localparam int             FPP_FPS_BIT         = 3;
    localparam int             FPP_FMOD_LSB        = 1;
    localparam int             FPP_BUSY_BIT        = 0;
    localparam int             FPP_AER_BIT         = 6;
    localparam int             FPP_ERR_BIT         = 1;
    localparam int             FPP_EXT_RAM_SELECT_BIT      = 1;

    // Launch keys and space codes
    localparam logic [3:0]     FPP_KEY_FIRST       = 4'h5;
    localparam logic [3:0]     FPP_KEY_SECOND      = 4'ha;
    localparam logic [1:0]     FPP_SPACE_CODE      = 2'h0;
    localparam logic [1:0]     FPP_SPACE_SIG       = 2'h1;
    localparam logic [1:0]     FPP_SPACE_FUSE      = 2'h2;
    localparam logic [1:0]     FPP_SPACE_RSVD      = 2'h3;
    localparam logic [15:0]    FPP_SIG_LAST        = 16'h027f;
    localparam logic [15:0]    FPP_FUSE_LAST       = 16'h00ff;
    localparam logic [7:0]     FPP_BLANK           = 8'hff;

    // Page buffer geometry
    localparam int             FPP_BUF_DEPTH       = 64;
    localparam int             FPP_IDX_W           = 6;
    localparam int             FPP_PAGE_W          = 9;
    localparam logic [5:0]     FPP_IDX_LAST        = 6'h3f;
    localparam logic [6:0]     FPP_PAGE_BASE       = 7'h00;

    // Erase and write times
    localparam int             FPP_CLK_PERIOD_NS   = 25;
    localparam int             FPP_PROG_TIME_MS    = 10;
    localparam int             FPP_PROG_CYCLES     = (FPP_PROG_TIME_MS * 1000000) / FPP_CLK_PERIOD_NS;
    localparam int             FPP_CNT_W           = 20;

    typedef enum logic [2:0] {
        FPP_IDLE,
        FPP_ERASE,
        FPP_ERASE_WAIT,
        FPP_WRITE,
        FPP_WRITE_WAIT
    } fpp_state_t;
endpackage : fpp_pkg

// ==== verilog/fpp_flash_page_program.sv ====
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
module fpp_flash_page_program
    import fpp_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = FPP_PROG_CYCLES
)(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  ce,
    input  wire logic [FPP_AXI_AW-1:0] awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    input  wire logic [FPP_AXI_AW-1:0] araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    input  wire logic                  cpu_instr_done,
    input  wire logic                  cpu_exec_internal,
    output logic                       cpu_stall,
    input  wire logic                  code_rd_en,
    input  wire logic [15:0]           code_rd_addr,
    output logic                       code_rd_valid,
    output logic [7:0]                 code_rd_data,
    input  wire logic                  xw_en,
    input  wire logic [15:0]           xw_addr,
    input  wire logic [7:0]            xw_data,
    output logic                       xram_we,
    output logic                       xram_ext_sel,
    output logic [15:0]                xram_addr,
    output logic [7:0]                 xram_wdata,
    input  wire logic                  brownout_async,
    output logic                       fl_rd_en,
    output logic                       fl_erase,
    output logic                       fl_prog,
    output logic [1:0]                 fl_space,
    output logic [15:0]                fl_addr,
    output logic [7:0]                 fl_prog_mask,
    input  wire logic [7:0]            fl_rd_data
);
    typedef struct packed {
        fpp_state_t                state;
        logic [FPP_CNT_W-1:0]      cnt;
        logic [FPP_IDX_W-1:0]      idx;
        logic [FPP_BUF_DEPTH-1:0]  loaded;
        logic [FPP_PAGE_W-1:0]     page;
        logic                      half;
        logic [1:0]                op_space;
        logic                      armed;
        logic                      page_buffer_map;
        logic [1:0]                fmod;
        logic                      aer;
        logic                      err;
        logic                      ext_ram;
        logic                      stall;
        logic                      bo_meta;
        logic                      bo_sync;
        logic                      aw_got;
        logic [FPP_AXI_AW-1:0]     aw_addr;
        logic                      w_got;
        logic [7:0]                w_data;
        logic                      w_lane0;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      rvalid;
        logic [7:0]                rdata;
        logic [1:0]                rresp;
        logic                      rd_pend;
        logic                      rd_ok;
        logic                      code_valid;
        logic [7:0]                code_data;
        logic                      xram_we;
        logic                      xram_ext;
        logic [15:0]               xram_addr;
        logic [7:0]                xram_wdata;
        logic                      fl_rd_en;
        logic                      fl_erase;
        logic                      fl_prog;
        logic [1:0]                fl_space;
        logic [15:0]               fl_addr;
        logic [7:0]                fl_mask;
    } fpp_regs_t;

    fpp_regs_t              q;
    fpp_regs_t              d;
    logic [7:0]             buf_mem [FPP_BUF_DEPTH];
    logic                   buf_we;
    logic                   prog_busy;
    logic                   wr_do;
    logic                   wr_ctl;
    logic [3:0]             wr_key;
    logic [1:0]             wr_fmod;
    logic                   launch;
    logic                   launch_go;
    logic                   rd_in_range;
    logic [FPP_CNT_W-1:0]   cnt_last;

    assign cnt_last  = FPP_CNT_W'(PROG_CYCLES - 1);
    assign prog_busy = (q.state != FPP_IDLE);

    // Decoded register write; the bus write itself is the key instruction
    assign wr_do     = q.aw_got & q.w_got & ~q.bvalid;
    assign wr_ctl    = wr_do & q.w_lane0 & (q.aw_addr == FPP_OFS_FLASH_CTRL);
    assign wr_key    = q.w_data[FPP_KEY_LSB +: 4];
    assign wr_fmod   = q.w_data[FPP_FMOD_LSB +: 2];
    assign launch    = wr_ctl & (wr_key == FPP_KEY_SECOND) & q.armed;
    assign launch_go = launch & ~prog_busy & (wr_fmod != FPP_SPACE_RSVD);

    // Readable range per space; reserved space reads blank
    always_comb
    begin
        case (q.fmod)
            FPP_SPACE_CODE: rd_in_range = 1'b1;
            FPP_SPACE_SIG:  rd_in_range = (code_rd_addr <= FPP_SIG_LAST);
            FPP_SPACE_FUSE: rd_in_range = (code_rd_addr <= FPP_FUSE_LAST);
            default:        rd_in_range = 1'b0;
        endcase
    end

    // Next-state logic for every register of the block except the page buffer storage
    always_comb
    begin
        logic [7:0] rtmp;
        rtmp         = 8'h00;
        d            = q;
        buf_we       = 1'b0;
        d.fl_rd_en   = 1'b0;
        d.fl_erase   = 1'b0;
        d.fl_prog    = 1'b0;
        d.xram_we    = 1'b0;
        d.code_valid = 1'b0;
        d.rd_pend    = 1'b0;
        // Brown-out level crosses in through two flops
        d.bo_meta    = brownout_async;
        d.bo_sync    = q.bo_meta;

        // Write address and data are taken independently
        if (awvalid && awready)
        begin
            d.aw_got  = 1'b1;
            d.aw_addr = awaddr;
        end
        if (wvalid && wready)
        begin
            d.w_got   = 1'b1;
            d.w_data  = wdata[7:0];
            d.w_lane0 = wstrb[0];
        end
        if (bvalid && bready)
            d.bvalid = 1'b0;

        // Register writes; only byte lane 0 carries register bits
        if (wr_do)
        begin
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = FPP_RESP_OKAY;
            case (q.aw_addr)
                FPP_OFS_FLASH_CTRL:
                    if (q.w_lane0)
                    begin
                        // Busy bit position is not written by software
                        d.page_buffer_map   = q.w_data[FPP_FPS_BIT];
                        d.fmod  = wr_fmod;
                        // Only key 5 arms; anything else drops the unlock state
                        d.armed = (wr_key == FPP_KEY_FIRST);
                    end
                FPP_OFS_EEPROM_CTRL:
                    if (q.w_lane0)
                    begin
                        d.aer = q.w_data[FPP_AER_BIT];
                        if (q.w_data[FPP_ERR_BIT])
                            d.err = 1'b0;
                    end
                FPP_OFS_AUX_CTRL:
                    if (q.w_lane0)
                        d.ext_ram = q.w_data[FPP_EXT_RAM_SELECT_BIT];
                default:
                    d.bresp = FPP_RESP_SLVERR;
            endcase
        end
        else if (cpu_instr_done)
        begin
            // Any instruction between the keys other than a register write aborts the launch
            d.armed = 1'b0;
        end

        // Register reads answer one cycle after the address is taken
        if (rvalid && rready)
            d.rvalid = 1'b0;
        if (arvalid && arready)
        begin
            d.rvalid = 1'b1;
            d.rresp  = FPP_RESP_OKAY;
            case (araddr)
                FPP_OFS_FLASH_CTRL:
                begin
                    rtmp[FPP_FPS_BIT]       = q.page_buffer_map;
                    rtmp[FPP_FMOD_LSB +: 2] = q.fmod;
                    rtmp[FPP_BUSY_BIT]      = prog_busy;
                end
                FPP_OFS_EEPROM_CTRL:
                begin
                    rtmp[FPP_AER_BIT] = q.aer;
                    rtmp[FPP_ERR_BIT] = q.err;
                end
                FPP_OFS_AUX_CTRL:
                    rtmp[FPP_EXT_RAM_SELECT_BIT] = q.ext_ram;
                default:
                    d.rresp = FPP_RESP_SLVERR;
            endcase
            d.rdata = rtmp;
        end

        // Code reads; the array path is lent to the sequencer while busy
        if (code_rd_en)
        begin
            d.rd_pend = 1'b1;
            d.rd_ok   = rd_in_range & ~prog_busy;
            if (rd_in_range && !prog_busy)
            begin
                d.fl_rd_en = 1'b1;
                d.fl_space = q.fmod;
                d.fl_addr  = code_rd_addr;
            end
        end
        if (q.rd_pend)
        begin
            d.code_valid = 1'b1;
            d.code_data  = q.rd_ok ? fl_rd_data : FPP_BLANK;
        end

        // Data writes: buffer map wins over the RAM select
        if (xw_en)
        begin
            if (q.page_buffer_map)
            begin
                if (!prog_busy)
                begin
                    d.page = xw_addr[15:7];
                    d.half = xw_addr[6];
                    if (!q.loaded[xw_addr[5:0]])
                    begin
                        buf_we                    = 1'b1;
                        d.loaded[xw_addr[5:0]]    = 1'b1;
                    end
                end
            end
            else
            begin
                d.xram_we    = 1'b1;
                d.xram_ext   = q.ext_ram;
                d.xram_addr  = xw_addr;
                d.xram_wdata = xw_data;
            end
        end

        // Programming sequencer
        case (q.state)
            FPP_IDLE:
                if (launch_go)
                begin
                    d.op_space = wr_fmod;
                    d.stall    = cpu_exec_internal;
                    d.idx      = '0;
                    d.cnt      = '0;
                    d.state    = q.aer ? FPP_ERASE : FPP_WRITE;
                end
            FPP_ERASE:
            begin
                // Whole page, both halves, goes blank
                d.fl_erase = 1'b1;
                d.fl_space = q.op_space;
                d.fl_addr  = {q.page, FPP_PAGE_BASE};
                d.cnt      = '0;
                d.state    = FPP_ERASE_WAIT;
            end
            FPP_ERASE_WAIT:
            begin
                d.cnt = q.cnt + 1'b1;
                if (q.cnt == cnt_last)
                begin
                    d.idx   = '0;
                    d.state = FPP_WRITE;
                end
            end
            FPP_WRITE:
            begin
                // Only loaded bytes are offered; zero bits form the mask
                if (q.loaded[q.idx])
                begin
                    d.fl_prog  = 1'b1;
                    d.fl_space = q.op_space;
                    d.fl_addr  = {q.page, q.half, q.idx};
                    d.fl_mask  = ~buf_mem[q.idx];
                end
                d.idx = q.idx + 1'b1;
                if (q.idx == FPP_IDX_LAST)
                begin
                    d.cnt   = '0;
                    d.state = FPP_WRITE_WAIT;
                end
            end
            FPP_WRITE_WAIT:
            begin
                d.cnt = q.cnt + 1'b1;
                if (q.cnt == cnt_last)
                begin
                    d.loaded = '0;
                    d.stall  = 1'b0;
                    d.state  = FPP_IDLE;
                end
            end
            default:
                d.state = FPP_IDLE;
        endcase

        // Brown-out cuts programming short; set wins over the clear above
        if (q.bo_sync && prog_busy)
        begin
            d.err    = 1'b1;
            d.loaded = '0;
            d.stall  = 1'b0;
            d.state  = FPP_IDLE;
        end
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            q <= '0;
        else if (ce)
            q <= d;
    end

    // Page buffer storage; content is only valid under the loaded bits
    always_ff @(posedge aclk)
    begin
        if (ce && buf_we)
            buf_mem[xw_addr[5:0]] <= xw_data;
    end

    assign awready       = ~q.aw_got & ~q.bvalid;
    assign wready        = ~q.w_got & ~q.bvalid;
    assign bvalid        = q.bvalid;
    assign bresp         = q.bresp;
    assign arready       = ~q.rvalid;
    assign rvalid        = q.rvalid;
    assign rdata         = {24'h000000, q.rdata};
    assign rresp         = q.rresp;
    assign cpu_stall     = q.stall;
    assign code_rd_valid = q.code_valid;
    assign code_rd_data  = q.code_data;
    assign xram_we       = q.xram_we;
    assign xram_ext_sel  = q.xram_ext;
    assign xram_addr     = q.xram_addr;
    assign xram_wdata    = q.xram_wdata;
    assign fl_rd_en      = q.fl_rd_en;
    assign fl_erase      = q.fl_erase;
    assign fl_prog       = q.fl_prog;
    assign fl_space      = q.fl_space;
    assign fl_addr       = q.fl_addr;
    assign fl_prog_mask  = q.fl_mask;

    // Checks; the clock enable is assumed high while they are meaningful
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn || !ce);

    property p_launch_busy;
        launch_go |=> prog_busy && (q.op_space == $past(wr_fmod));
    endproperty
    a_launch_busy: assert property (p_launch_busy) else $error("launch did not start");

    property p_rsvd_none;
        launch && (wr_fmod == FPP_SPACE_RSVD) && !prog_busy |=> !prog_busy;
    endproperty
    a_rsvd_none: assert property (p_rsvd_none) else $error("reserved space launched");

    property p_gap_abort;
        q.armed && cpu_instr_done && !wr_do |=> !q.armed;
    endproperty
    a_gap_abort: assert property (p_gap_abort) else $error("unlock kept over gap");

    property p_bad_key;
        wr_ctl && (wr_key != FPP_KEY_FIRST) |=> !q.armed ##1 !launch;
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("unlock kept after bad key");

    property p_brownout_err;
        q.bo_sync && prog_busy |=> q.err && !prog_busy && (q.loaded == '0);
    endproperty
    a_brownout_err: assert property (p_brownout_err) else $error("brown-out not flagged");

    property p_end_clears;
        $fell(prog_busy) |-> (q.loaded == '0) && !cpu_stall;
    endproperty
    a_end_clears: assert property (p_end_clears) else $error("buffer not cleared");

    property p_map_wins;
        xw_en && q.page_buffer_map |=> !xram_we;
    endproperty
    a_map_wins: assert property (p_map_wins) else $error("mapped write reached RAM");

    property p_rsvd_read;
        code_rd_en && (q.fmod == FPP_SPACE_RSVD) |=> !fl_rd_en ##1 (code_rd_data == FPP_BLANK);
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved read not blank");

    property p_no_reload;
        !prog_busy && $past(!prog_busy) |-> ((q.loaded & $past(q.loaded)) == $past(q.loaded));
    endproperty
    a_no_reload: assert property (p_no_reload) else $error("loaded bit lost");

    property p_erase_first;
        launch_go && q.aer |=> ##1 fl_erase && (fl_addr[6:0] == FPP_PAGE_BASE);
    endproperty
    a_erase_first: assert property (p_erase_first) else $error("auto-erase missing");

    property p_stall_busy;
        cpu_stall |-> prog_busy;
    endproperty
    a_stall_busy: assert property (p_stall_busy) else $error("stall without busy");

    c_launch:    cover property (launch_go ##1 prog_busy);
    c_erase:     cover property (fl_erase);
    c_brownout:  cover property (q.bo_sync && prog_busy);
    c_buf_load:  cover property (xw_en && q.page_buffer_map && !prog_busy);
endmodule : fpp_flash_page_program

// ==== bench/fpp_flash_model.sv ====
`timescale 1ns/100ps
// Flash array behind the sequencer; one byte array, space select ignored
module fpp_flash_model (
    input  wire logic        aclk,
    input  wire logic        fl_rd_en,
    input  wire logic        fl_erase,
    input  wire logic        fl_prog,
    input  wire logic [15:0] fl_addr,
    input  wire logic [7:0]  fl_prog_mask,
    output logic [7:0]       fl_rd_data
);
    logic [7:0] mem [65536];
    logic [7:0] last_q;
    // Known fill so that untouched bytes can be told apart from blank ones
    initial foreach (mem[i]) mem[i] = 8'hc3;
    // Erase blanks a whole page; programming can only clear bits
    always @(posedge aclk)
    begin
        if (fl_erase) for (int i = 0; i < 128; i++) mem[{fl_addr[15:7], i[6:0]}] <= 8'hff;
        if (fl_prog) mem[fl_addr] <= mem[fl_addr] & ~fl_prog_mask;
        if (fl_rd_en) last_q <= mem[fl_addr];
    end
    // Outside a read the lines show no stale byte
    assign fl_rd_data = fl_rd_en ? mem[fl_addr] : ~last_q;
endmodule : fpp_flash_model

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
    import fpp_pkg::*;
    logic        aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, awready, wready;
    logic        bvalid, arready, rvalid, cpu_instr_done, cpu_exec_internal, cpu_stall, xw_en;
    logic        code_rd_en, code_rd_valid, xram_we, xram_ext_sel, brownout_async;
    logic        fl_rd_en, fl_erase, fl_prog;
    logic [1:0]  bresp, rresp, fl_space;
    logic [3:0]  wstrb;
    logic [7:0]  awaddr, araddr, code_rd_data, xw_data, xram_wdata, fl_prog_mask, fl_rd_data, v;
    logic [15:0] code_rd_addr, xw_addr, xram_addr, fl_addr;
    logic [31:0] wdata, rdata;
    int          error_cnt, comparisons;
    localparam logic [7:0] CTL = FPP_OFS_FLASH_CTRL;
    // Short programming time keeps each launch under a hundred cycles
    fpp_flash_page_program #(.PROG_CYCLES(8)) i_fpp_flash_page_program (.*);
    fpp_flash_model i_fpp_flash_model (.*);
    // 40 MHz clock
    initial
    begin
        aclk = 0;
        forever #12.5 aclk = ~aclk;
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // Register write; each channel is released once it is taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ta, tw;
        @(posedge aclk);
        {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, 24'h0, d, 4'hf, 3'b111};
        do
        begin
            @(negedge aclk);
            {ta, tw} = {awready & awvalid, wready & wvalid};
            @(posedge aclk);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
        end while (awvalid | wvalid);
        do @(negedge aclk); while (!bvalid);
        chk("bresp", bresp, FPP_RESP_OKAY);
        @(posedge aclk);
        bready <= 0;
    endtask : wr
    // Register read, masked compare; addresses past the map must be refused
    task automatic rc(input string n, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 0;
        do @(negedge aclk); while (!rvalid);
        chk(n, {rresp, rdata & {24'h0, m}}, {(a > 8'h08) ? FPP_RESP_SLVERR : FPP_RESP_OKAY, 24'h0, e});
        v = rdata[7:0];
        @(posedge aclk);
        rready <= 0;
    endtask : rc
    // Code read; the byte is due exactly two cycles after the request
    task automatic cr(input logic [15:0] a, input logic [7:0] e);
        @(posedge aclk);
        {code_rd_en, code_rd_addr} <= {1'b1, a};
        @(posedge aclk);
        code_rd_en <= 0;
        repeat (2) @(negedge aclk);
        chk("code", {code_rd_valid, code_rd_data}, {1'b1, e});
    endtask : cr
    task automatic xw(input logic [15:0] a, input logic [7:0] d, input logic we);
        @(posedge aclk);
        {xw_en, xw_addr, xw_data} <= {1'b1, a, d};
        @(posedge aclk);
        xw_en <= 0;
        @(negedge aclk);
        chk("xram_we", xram_we, we);
        if (we) chk("xram", {xram_addr, xram_wdata}, {a, d});
    endtask : xw
    // Key pair with an optional disturbance between: 1 instr, 2 other write, 3 brown-out later
    task automatic launch(input logic [1:0] sp, input int mid, input logic go);
        wr(CTL, {4'h5, 1'b0, sp, 1'b0});
        if (mid == 1) cpu_instr_done <= 1;
        @(posedge aclk);
        cpu_instr_done <= 0; // Interrupts stay off, nothing retires while busy
        if (mid == 2) wr(CTL, {4'h3, 1'b0, sp, 1'b0});
        wr(CTL, {4'ha, 1'b0, sp, 1'b0});
        @(negedge aclk);
        chk("stall", cpu_stall, go & cpu_exec_internal);
        rc("busy", CTL, 8'h01, {7'h0, go});
        brownout_async <= (mid == 3);
        for (int i = 0; i < 60 && v[0]; i++) rc("poll", CTL, 8'h00, 8'h00);
        brownout_async <= 0;
        chk("done", v[0], 0);
    endtask : launch
    task automatic report_and_stop();
        if (error_cnt == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    // Whole run is under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        report_and_stop();
    end
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, cpu_instr_done, code_rd_en} = 0;
        {xw_en, brownout_async, awaddr, araddr, wdata, wstrb, xw_addr, xw_data, code_rd_addr} = 0;
        {ce, cpu_exec_internal} = 2'b11;
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        rc("ctl reset", CTL, 8'hff, 8'h00);
        rc("unmapped", 8'h20, 8'h00, 8'h00);
        cr(16'h1200, 8'hc3);
        wr(CTL, 8'h06);
        cr(16'h1200, FPP_BLANK);
        wr(CTL, 8'h02);
        cr(16'h0280, FPP_BLANK);
        wr(FPP_OFS_AUX_CTRL, 8'h02);
        wr(CTL, 8'h08);
        xw(16'h1200, 8'h81, 0);
        xw(16'h1200, 8'h00, 0);
        xw(16'h1205, 8'h00, 0);
        wr(CTL, 8'h01);
        rc("busy sw", CTL, 8'hff, 8'h00);
        xw(16'h0010, 8'h55, 1);
        chk("ext sel", xram_ext_sel, 1);
        launch(2'b00, 0, 1);
        cr(16'h1200, 8'h81);
        cr(16'h1205, 8'h00);
        cr(16'h1201, 8'hc3);
        for (int m = 1; m < 3; m++) launch(2'b00, m, 0);
        launch(2'b11, 0, 0);
        for (int s = 1; s < 3; s++) launch(s[1:0], 0, 1);
        cpu_exec_internal <= 0;
        wr(FPP_OFS_EEPROM_CTRL, 8'h40);
        wr(CTL, 8'h08);
        xw(16'h0040, 8'h33, 0);
        xw(16'h1243, 8'h22, 0);
        launch(2'b00, 0, 1);
        cr(16'h1240, 8'h33);
        cr(16'h1243, 8'h22);
        cr(16'h1241, FPP_BLANK);
        cr(16'h1200, FPP_BLANK);
        cr(16'h0040, 8'hc3);
        rc("err idle", FPP_OFS_EEPROM_CTRL, 8'h02, 8'h00);
        launch(2'b00, 3, 1);
        rc("err set", FPP_OFS_EEPROM_CTRL, 8'h02, 8'h02);
        report_and_stop();
    end
endmodule : tb_top
